/* verilog/hsw_params.svh */
// Constants of the heater status word logic: codes, temperatures and field positions.
`ifndef HSW_PARAMS_SVH
`define HSW_PARAMS_SVH
`define HSW_ERR_LINE_LOST 10'h0c9
`define HSW_ERR_LINE_ACK 10'h385
`define HSW_ERR_NONE 10'h000
`define HSW_START_INVALID 16'hff9d
`define HSW_START_MIN 16'hffec
`define HSW_START_MAX 16'h01f4
`define HSW_ERR_LSB 0
`define HSW_ERR_MSB 9
`define HSW_RESET_WORD 16'h0000
`define HSW_FLAG_RESET 1'b0
`define HSW_STANDBY_RESET 1'b1
`endif

/* verilog/hsw_pkg.sv */
// Types of the heater status word logic.
package hsw_pkg;
   typedef enum logic [2:0] {
      HSW_WAIT_LINE = 3'b000,
      HSW_RUN = 3'b001,
      HSW_ALARM_LOST = 3'b010,
      HSW_ALARM_ACKED = 3'b011,
      HSW_ALARM_NOLINE = 3'b100
   } hsw_state_e;
   typedef logic [15:0] hsw_word_t;
endpackage : hsw_pkg

/* verilog/hsw_status_word.sv */
// Status word logic: standby, alarm sequence, measurement gap and output words.
`timescale 1ns/1ns
`include "hsw_params.svh"
module hsw_status_word
   import hsw_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic clk_en_i,
   input wire logic pd_cycle_i,
   input wire logic line_voltage_i,
   input wire logic fault_clear_request_i,
   input wire logic measure_pause_request_i,
   input wire logic heat_cycle_request_i,
   input wire logic measure_taken_i,
   input wire logic calibrating_i,
   input wire logic fault_i,
   input wire logic [9:0] fault_code_i,
   input wire logic [15:0] temp_i,
   output logic standby_indicator_o,
   output logic alarm_flag_o,
   output logic measure_gap_flag_o,
   output logic sealing_enable_o,
   output logic [15:0] actual_temp_o,
   output logic [15:0] start_temp_o,
   output logic [15:0] error_word_o
);
   // Line voltage comes from a detector outside the clock domain; three stages, change accepted when last two agree.
   logic [2:0] line_sync_q;
   logic line_q;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         line_sync_q <= 3'h0;
         line_q <= 1'b0;
      end else if (clk_en_i) begin
         line_sync_q <= {line_sync_q[1:0], line_voltage_i};
         if (line_sync_q[2] == line_sync_q[1]) begin
            line_q <= line_sync_q[2];
         end
      end
   end

   // Edge of the fault-clear request is the acknowledge; holding it does not repeat it.
   logic clr_prev_q;
   logic ack;
   assign ack = fault_clear_request_i & ~clr_prev_q;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         clr_prev_q <= 1'b0;
      end else if (clk_en_i) begin
         clr_prev_q <= fault_clear_request_i;
      end
   end

   // Line voltage alarm sequence.
   hsw_state_e state_q;
   hsw_state_e state_d;
   always_comb begin
      state_d = state_q;
      case (state_q)
         HSW_WAIT_LINE: begin
            if (line_q) begin
               state_d = HSW_RUN;
            end
         end
         HSW_RUN: begin
            if (!line_q) begin
               state_d = HSW_ALARM_LOST;
            end
         end
         HSW_ALARM_LOST: begin
            // Alarm holds until acknowledged, line back or not.
            if (ack && !line_q) begin
               state_d = HSW_ALARM_NOLINE;
            end else if (ack) begin
               state_d = HSW_ALARM_ACKED;
            end
         end
         HSW_ALARM_ACKED: begin
            // Cleared only once the request has been released.
            if (!fault_clear_request_i) begin
               state_d = line_q ? HSW_RUN : HSW_ALARM_LOST;
            end
         end
         HSW_ALARM_NOLINE: begin
            if (ack && line_q) begin
               state_d = HSW_ALARM_ACKED;
            end
         end
         default: begin
            state_d = HSW_WAIT_LINE;
         end
      endcase
   end
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= HSW_WAIT_LINE;
      end else if (clk_en_i) begin
         state_q <= state_d;
      end
   end

   // Last measured temperature; a gap in measurement keeps the older value, which is what a heat cycle
   // taken during the gap must report as its start.
   hsw_word_t last_temp_q;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         last_temp_q <= `HSW_RESET_WORD;
      end else if (clk_en_i) begin
         if (measure_taken_i) begin
            last_temp_q <= temp_i;
         end
      end
   end

   // Previous heat request, to find the edge at which a heat cycle is taken.
   // Holding the request high does not take a second start value.
   logic heat_prev_q;
   logic heat_rise;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         heat_prev_q <= `HSW_FLAG_RESET;
      end else if (clk_en_i) begin
         heat_prev_q <= heat_cycle_request_i;
      end
   end
   assign heat_rise = heat_cycle_request_i & ~heat_prev_q;

   // Clamp of the last measurement into the valid start range. A broken probe can read far outside it,
   // and the master must never mistake such a reading for the invalid marker.
   hsw_word_t start_clamped;
   always_comb begin
      start_clamped = last_temp_q;
      if ($signed(last_temp_q) < $signed(`HSW_START_MIN)) begin
         start_clamped = `HSW_START_MIN;
      end else if ($signed(last_temp_q) > $signed(`HSW_START_MAX)) begin
         start_clamped = `HSW_START_MAX;
      end
   end

   // Start temperature, taken once at the first edge of a heat cycle and held for the rest of it.
   hsw_word_t start_cap_q;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         start_cap_q <= `HSW_START_INVALID;
      end else if (clk_en_i && heat_rise) begin
         start_cap_q <= start_clamped;
      end
   end

   // Start word of the next snapshot. On the first edge of a request the clamp is used directly, so a
   // strobe on that very edge does not show the capture of an earlier cycle.
   hsw_word_t start_now;
   always_comb begin
      start_now = `HSW_START_INVALID;
      if (heat_rise) begin
         start_now = start_clamped;
      end else if (heat_cycle_request_i) begin
         start_now = start_cap_q;
      end
   end

   // Alarm and error code follow the alarm sequence. The state and the outside fault alone decide them, so a held fault-clear
   // request cannot drop the alarm before it is released, though its edge can switch the code between 0x0c9 and 0x385.
   logic alarm_now;
   logic [9:0] code_now;
   always_comb begin
      alarm_now = 1'b0;
      code_now = `HSW_ERR_NONE;
      case (state_q)
         HSW_ALARM_LOST: begin
            alarm_now = 1'b1;
            code_now = `HSW_ERR_LINE_LOST;
         end
         HSW_ALARM_ACKED: begin
            alarm_now = 1'b1;
            code_now = `HSW_ERR_LINE_LOST;
         end
         HSW_ALARM_NOLINE: begin
            alarm_now = 1'b1;
            code_now = `HSW_ERR_LINE_ACK;
         end
         default: begin
            alarm_now = 1'b0;
         end
      endcase
      // An outside fault raises the alarm while it lasts; it does not latch, and the line code keeps priority.
      if (fault_i) begin
         alarm_now = 1'b1;
         if (code_now == `HSW_ERR_NONE) begin
            code_now = fault_code_i;
         end
      end
   end

   // Standby answers either request at once and also covers the wait for the first line voltage.
   // After a 901 alarm it follows the requests only, so the master still sees its handshake.
   logic standby_now;
   always_comb begin
      // The pause request only acknowledges; it never changes the alarm state.
      standby_now = fault_clear_request_i | measure_pause_request_i;
      if (state_q == HSW_WAIT_LINE) begin
         standby_now = 1'b1;
      end
   end

   // Measurement gap: a heat cycle is running and no measurement came this cycle.
   // The flag drops on the first strobe after measurement resumes.
   logic gap_now;
   assign gap_now = heat_cycle_request_i & ~measure_taken_i;

   // Sealing is permitted only in control mode with no alarm; lifting a pause needs no init phase.
   // A pause never touches the sequence, so any fault is still in force when it lifts.
   logic seal_now;
   assign seal_now = (state_q == HSW_RUN) && !alarm_now && !measure_pause_request_i;

   // One load strobe for every output, so the master never samples a half-updated snapshot.
   // A low clock enable also blocks the strobe, which freezes the snapshot with the rest.
   logic load;
   assign load = clk_en_i & pd_cycle_i;

   // Standby bit of the snapshot. It resets high because the device always starts waiting for line voltage.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         standby_indicator_o <= `HSW_STANDBY_RESET;
      end else if (load) begin
         standby_indicator_o <= standby_now;
      end
   end

   // Alarm bit of the snapshot; it stays set while the sequence sits in any alarm state.
   // Only the release of an acknowledge moves the sequence out of those states.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         alarm_flag_o <= `HSW_FLAG_RESET;
      end else if (load) begin
         alarm_flag_o <= alarm_now;
      end
   end

   // Measurement gap bit of the snapshot.
   // It shows the cycle of the strobe only; short gaps between strobes are not seen.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         measure_gap_flag_o <= `HSW_FLAG_RESET;
      end else if (load) begin
         measure_gap_flag_o <= gap_now;
      end
   end

   // Sealing permission of the snapshot; it resets low so nothing seals before the line has been seen.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sealing_enable_o <= `HSW_FLAG_RESET;
      end else if (load) begin
         sealing_enable_o <= seal_now;
      end
   end

   // Actual temperature word, forced to zero during calibration or any alarm, since the measurement
   // is then not trustworthy.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         actual_temp_o <= `HSW_RESET_WORD;
      end else if (load) begin
         actual_temp_o <= (calibrating_i || alarm_now) ? `HSW_RESET_WORD : temp_i;
      end
   end

   // Start temperature word; outside a heat cycle it shows the invalid marker.
   // It resets to that marker, as no heat cycle can be running yet.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         start_temp_o <= `HSW_START_INVALID;
      end else if (load) begin
         start_temp_o <= start_now;
      end
   end

   // Error word; the upper six bits stay zero, and the field is empty while no alarm is set.
   // The master therefore needs to read the code only when the alarm bit is high.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         error_word_o <= `HSW_RESET_WORD;
      end else if (load) begin
         error_word_o <= alarm_now ? {6'h00, code_now} : `HSW_RESET_WORD;
      end
   end
endmodule : hsw_status_word

/* test/hsw_status_word_chk.sv */
// Checker of the heater status word ports.
`timescale 1ns/1ns
module hsw_chk(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic clk_en_i,
   input wire logic pd_cycle_i,
   input wire logic fault_clear_request_i,
   input wire logic measure_pause_request_i,
   input wire logic heat_cycle_request_i,
   input wire logic measure_taken_i,
   input wire logic standby_indicator_o,
   input wire logic alarm_flag_o,
   input wire logic measure_gap_flag_o,
   input wire logic [15:0] actual_temp_o,
   input wire logic [15:0] start_temp_o,
   input wire logic [15:0] error_word_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // Snapshot, alarm and field checks; the pause request is held three edges, heat and measurement two, so the strobe sees them.
   property p_hold; !(clk_en_i && pd_cycle_i) |=> $stable(alarm_flag_o) && $stable(error_word_o); endproperty
   a_hold: assert property (p_hold) else $error("output moved off strobe");
   property p_err; error_word_o[15:10] == 6'h00 && (alarm_flag_o || error_word_o == 16'h0000); endproperty
   a_err: assert property (p_err) else $error("error word");
   property p_zero; alarm_flag_o |-> actual_temp_o == 16'h0000; endproperty
   a_zero: assert property (p_zero) else $error("actual not zero");
   property p_range; start_temp_o != 16'hff9d |-> $signed(start_temp_o) >= -20 && $signed(start_temp_o) <= 500;
   endproperty
   a_range: assert property (p_range) else $error("start out of range");
   property p_pause; (measure_pause_request_i && clk_en_i)[*3] ##0 pd_cycle_i |=> standby_indicator_o; endproperty
   a_pause: assert property (p_pause) else $error("no standby on pause");
   property p_clr; alarm_flag_o && error_word_o[9:0] == 10'h0c9 && fault_clear_request_i |=> alarm_flag_o;
   endproperty
   a_clr: assert property (p_clr) else $error("alarm dropped");
   property p_gap; (heat_cycle_request_i && !measure_taken_i && clk_en_i)[*2] ##0 pd_cycle_i |=> measure_gap_flag_o;
   endproperty
   a_gap: assert property (p_gap) else $error("gap flag low");
   property p_meas; (measure_taken_i && clk_en_i)[*2] ##0 pd_cycle_i |=> !measure_gap_flag_o; endproperty
   a_meas: assert property (p_meas) else $error("gap flag high");
endmodule : hsw_chk

/* test/hsw_master_model.sv */
// Fieldbus master model making reset and pause requests.
`timescale 1ns/1ns
module hsw_master(
   input wire logic clk_i,
   input wire logic standby_i,
   input wire logic start_i,
   input wire logic kind_i,
   output logic clear_o,
   output logic pause_o
);
   logic req_q = 1'b0;
   // The request is dropped only once standby has confirmed it.
   always @(posedge clk_i) req_q <= start_i | (req_q & ~standby_i);
   assign clear_o = req_q & ~kind_i;
   assign pause_o = req_q & kind_i;
endmodule : hsw_master

/* test/test_heater_status_word_logic.sv */
// Self-checking bench of the heater status word logic.
`timescale 1ns/1ns
module test_heater_status_word_logic;
   import hsw_pkg::*;
   logic ref_clk_i = 0, rst_i = 1, en = 1, pd = 0, line = 0, start = 0, kind = 0, heat = 0, meas = 0, cal = 0;
   logic fault = 0;
   logic [9:0] code = 10'h000;
   logic clr_req, pause_req, sb, alarm, gap, seal;
   hsw_word_t act, start_word, ew, temp = 16'h0000;
   integer mismatches = 0, compares = 0, seed = 9, i;
   // Clock of 20 ns.
   always #10 ref_clk_i = ~ref_clk_i;
   hsw_master u_mst(.clk_i(ref_clk_i), .standby_i(sb), .start_i(start), .kind_i(kind), .clear_o(clr_req),
      .pause_o(pause_req));
   hsw_status_word u_dut(.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(en), .pd_cycle_i(pd), .line_voltage_i(line),
      .fault_clear_request_i(clr_req), .measure_pause_request_i(pause_req), .heat_cycle_request_i(heat),
      .measure_taken_i(meas), .calibrating_i(cal), .fault_i(fault), .fault_code_i(code), .temp_i(temp),
      .standby_indicator_o(sb), .alarm_flag_o(alarm), .measure_gap_flag_o(gap), .sealing_enable_o(seal),
      .actual_temp_o(act), .start_temp_o(start_word), .error_word_o(ew));
   // Six idle cycles let the line synchroniser settle before the strobe.
   task step;
      repeat (6) @(negedge ref_clk_i);
      pd = 1;
      @(negedge ref_clk_i);
      pd = 0;
   endtask : step
   task chk(input string n, input hsw_word_t e, input hsw_word_t g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   function automatic hsw_word_t clamp(input hsw_word_t t);
      return $signed(t) < -20 ? 16'hffec : ($signed(t) > 500 ? 16'h01f4 : t);
   endfunction : clamp
   task end_of_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   // A hung run counts as a mismatch.
   initial begin
      #1000000;
      mismatches++;
      end_of_test;
   end
   // Flags are packed as standby, alarm, gap, sealing.
   initial begin
      repeat (2) @(negedge ref_clk_i);
      rst_i = 0;
      step;
      chk("flags", 16'h0008, {sb, alarm, gap, seal});
      chk("start", 16'hff9d, start_word);
      line = 1;
      step;
      chk("flags", 16'h0001, {sb, alarm, gap, seal});
      line = 0;
      step;
      chk("flags", 16'h0004, {sb, alarm, gap, seal});
      chk("error", 16'h00c9, ew);
      line = 1;
      step;
      chk("error", 16'h00c9, ew);
      // A pause request during the alarm is answered but clears nothing.
      kind = 1;
      start = 1;
      step;
      chk("flags", 16'h000c, {sb, alarm, gap, seal});
      start = 0;
      step;
      chk("flags", 16'h0004, {sb, alarm, gap, seal});
      chk("error", 16'h00c9, ew);
      kind = 0;
      start = 1;
      step;
      chk("flags", 16'h000c, {sb, alarm, gap, seal});
      start = 0;
      step;
      chk("flags", 16'h0001, {sb, alarm, gap, seal});
      line = 0;
      step;
      start = 1;
      step;
      chk("error", 16'h0385, ew);
      start = 0;
      step;
      line = 1;
      step;
      start = 1;
      step;
      start = 0;
      step;
      chk("flags", 16'h0001, {sb, alarm, gap, seal});
      kind = 1;
      start = 1;
      step;
      chk("standby", 16'h0001, {15'h0000, sb});
      start = 0;
      step;
      chk("flags", 16'h0001, {sb, alarm, gap, seal});
      // Enable low freezes the snapshot; then an outside fault raises the alarm with its own code.
      temp = 16'h0050;
      code = 10'($random(seed));
      en = 0;
      fault = 1;
      step;
      chk("frozen", 16'h0001, {sb, alarm, gap, seal});
      en = 1;
      step;
      chk("flags", 16'h0004, {sb, alarm, gap, seal});
      chk("error", {6'h00, code}, ew);
      chk("actual", 16'h0000, act);
      fault = 0;
      step;
      chk("actual", temp, act);
      // Corner temperatures first, then random ones.
      for (i = 0; i < 20; i++) begin
         temp = i == 0 ? 16'hff00 : (i == 1 ? 16'h0400 : 16'($random(seed) % 700));
         meas = 1;
         step;
         chk("actual", temp, act);
         heat = 1;
         step;
         chk("start", clamp(temp), start_word);
         meas = 0;
         step;
         chk("gap", 16'h0001, {15'h0000, gap});
         meas = 1;
         cal = 1;
         step;
         chk("gap", 16'h0000, {15'h0000, gap});
         chk("actual", 16'h0000, act);
         cal = 0;
         heat = 0;
         step;
         chk("start", 16'hff9d, start_word);
      end
      end_of_test;
   end
endmodule : test_heater_status_word_logic
bind hsw_status_word hsw_chk u_chk(
   .ref_clk_i(ref_clk_i),
   .rst_i(rst_i),
   .clk_en_i(clk_en_i),
   .pd_cycle_i(pd_cycle_i),
   .fault_clear_request_i(fault_clear_request_i),
   .measure_pause_request_i(measure_pause_request_i),
   .heat_cycle_request_i(heat_cycle_request_i),
   .measure_taken_i(measure_taken_i),
   .standby_indicator_o(standby_indicator_o),
   .alarm_flag_o(alarm_flag_o),
   .measure_gap_flag_o(measure_gap_flag_o),
   .actual_temp_o(actual_temp_o),
   .start_temp_o(start_temp_o),
   .error_word_o(error_word_o)
);
